// >>> common/ahc_hex_conv_defs.vh
// Functional notes
// R01: a conversion runs only while the execution bit is set; operands come from registers.
// R02: bit 7 of each source byte is the parity position, not part of the character.
// R03: designator top digit selects parity: 0 none, 1 even, 2 odd.
// R04: no parity: any byte with bit 7 set is an error.
// R05: even parity: any byte with an odd count of ones is an error.
// R06: odd parity: any byte with an even count of ones is an error.
// R07: designator 0121 is no parity, upper byte first, three bytes, digit 1.
// R08: designator 1011 is even parity, lower byte first, two bytes, digit 1.
// R09: the digit value depends on the lower seven bits only.
// R10: codes 30-39 give digits 0-9, codes 41-46 give digits A-F.
// R11: bytes advance upward into the next word; digits advance upward, 3 wraps to 0.
// R12: destination digits not written keep their previous contents.
// R13: error flag set on parity, code or designator range fault, else cleared.
// R14: on any error the destination word stays entirely unchanged.
`ifndef AHC_HEX_CONV_DEFS_VH
`define AHC_HEX_CONV_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define AHC_OFF_CTRL 8'h00
`define AHC_OFF_DESIG 8'h04
`define AHC_OFF_SRC0 8'h08
`define AHC_OFF_SRC1 8'h0C
`define AHC_OFF_SRC2 8'h10
`define AHC_OFF_DEST 8'h14
`define AHC_OFF_STATUS 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AHC_CTRL_EXEC 0
`define AHC_STAT_ERR 0
`define AHC_STAT_BUSY 1
`define AHC_DSG_PAR 15:12
`define AHC_DSG_SBYTE 11:8
`define AHC_DSG_CNT 7:4
`define AHC_DSG_DIG 3:0

// ----------------------------------------------------------------
// field limits, codes and reset values
// ----------------------------------------------------------------
`define AHC_PAR_NONE 2'h0
`define AHC_PAR_EVEN 2'h1
`define AHC_PAR_ODD 2'h2
`define AHC_PAR_MAX 4'h2
`define AHC_SBYTE_MAX 4'h1
`define AHC_CNT_MAX 4'h3
`define AHC_DIG_MAX 4'h3
`define AHC_CHR_NUM_LO 7'h30
`define AHC_CHR_NUM_HI 7'h39
`define AHC_CHR_ALPHA_LO 7'h41
`define AHC_CHR_ALPHA_HI 7'h46
`define AHC_CHR_ALPHA_BIAS 7'h37
`define AHC_RST_WORD16 16'h0000
`define AHC_RST_WORD32 32'h0000_0000
`define AHC_HSIZE_WORD 3'h2

`endif

// >>> rtl/ahc_pair_buf.v
`timescale 1ns/1ns
module ahc_pair_buf #(
    parameter WIDTH = 8
) (
    input wire mclk,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    // ------------------------------------------------------------
    // two-slot storage with wrap-around pointers
    // ------------------------------------------------------------
    reg [WIDTH-1:0] slot_reg [0:1];
    reg wr_ptr_reg;
    reg rd_ptr_reg;
    reg [1:0] fill_reg;
    wire push;
    wire pop;

    assign in_ready = (fill_reg != 2'h2);
    assign out_valid = (fill_reg != 2'h0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = slot_reg[rd_ptr_reg];

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_slot
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    slot_reg[i] <= {WIDTH{1'b0}};
                end else if (push && (wr_ptr_reg == i)) begin
                    slot_reg[i] <= in_data;
                end
            end
        end
    endgenerate

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fill_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                fill_reg <= fill_reg + 2'h1;
            end else if (pop && !push) begin
                fill_reg <= fill_reg - 2'h1;
            end
        end
    end

endmodule

// >>> rtl/ahc_hex_conv.v
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "ahc_hex_conv_defs.vh"
module ahc_hex_conv (
    input wire mclk,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output wire error_flag_out,
    output wire busy_out
);

    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg pend_reg;
    reg [7:0] addr_reg;
    reg wr_reg;
    reg size_ok_reg;
    reg hready_reg;
    reg [31:0] hrdata_reg;
    reg [31:0] rdata_next;

    reg exec_reg;
    reg [15:0] desig_reg;
    reg [15:0] src0_reg;
    reg [15:0] src1_reg;
    reg [15:0] src2_reg;
    reg [15:0] dest_reg;
    reg err_reg;

    reg [2:0] state_reg;
    reg [1:0] par_reg;
    reg [1:0] cnt_reg;
    reg [1:0] dig_reg;
    reg [2:0] byte_idx_reg;
    reg [2:0] push_cnt_reg;
    reg [1:0] pop_cnt_reg;
    reg [15:0] work_reg;
    reg perr_reg;
    reg busy_reg;
    reg hresp_reg;
    reg [47:0] src_lat_reg;
    reg par_bad;

    wire acc;
    wire bus_wr;
    wire start;
    wire range_bad;
    wire run;
    wire [47:0] src_flat;
    wire in_valid;
    wire in_ready;
    wire [7:0] in_data;
    wire out_valid;
    wire out_ready;
    wire [7:0] out_data;
    wire [4:0] dec;
    wire [15:0] field_max;
    wire [3:0] field_bad;
    wire [15:0] lane_mask;
    wire byte_bad;
    wire pop;

    // ------------------------------------------------------------
    // character decode: {bad, digit}
    // ------------------------------------------------------------
    function [4:0] hex_decode;
        input [6:0] c;
        reg [6:0] d;
        begin
            d = 7'h00;
            if (c >= `AHC_CHR_NUM_LO && c <= `AHC_CHR_NUM_HI) begin
                d = c - `AHC_CHR_NUM_LO; // see R10
                hex_decode = {1'b0, d[3:0]};
            end else if (c >= `AHC_CHR_ALPHA_LO && c <= `AHC_CHR_ALPHA_HI) begin
                d = c - `AHC_CHR_ALPHA_BIAS; // see R10
                hex_decode = {1'b0, d[3:0]};
            end else begin
                hex_decode = {1'b1, 4'h0};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // ahb-lite slave: one wait state per transfer, always okay
    // ------------------------------------------------------------
    assign acc = hsel & htrans[1] & hready;
    assign bus_wr = pend_reg & wr_reg & size_ok_reg;
    assign hrdata = hrdata_reg;
    assign hreadyout = hready_reg;
    assign hresp = hresp_reg;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
            size_ok_reg <= 1'b0;
            hready_reg <= 1'b1;
            hrdata_reg <= `AHC_RST_WORD32;
        end else if (pend_reg) begin
            pend_reg <= 1'b0;
            hready_reg <= 1'b1;
            hrdata_reg <= wr_reg ? `AHC_RST_WORD32 : rdata_next;
        end else if (acc) begin
            pend_reg <= 1'b1;
            addr_reg <= haddr[7:0];
            wr_reg <= hwrite;
            size_ok_reg <= (hsize == `AHC_HSIZE_WORD);
            hready_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // response flop: the slave never answers with an error
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register read mux, unmapped offsets read zero
    // ------------------------------------------------------------
    always @* begin
        rdata_next = `AHC_RST_WORD32;
        case (addr_reg)
            `AHC_OFF_CTRL: rdata_next[`AHC_CTRL_EXEC] = exec_reg;
            `AHC_OFF_DESIG: rdata_next[15:0] = desig_reg;
            `AHC_OFF_SRC0: rdata_next[15:0] = src0_reg;
            `AHC_OFF_SRC1: rdata_next[15:0] = src1_reg;
            `AHC_OFF_SRC2: rdata_next[15:0] = src2_reg;
            `AHC_OFF_DEST: rdata_next[15:0] = dest_reg;
            `AHC_OFF_STATUS: begin
                rdata_next[`AHC_STAT_ERR] = err_reg;
                rdata_next[`AHC_STAT_BUSY] = busy_reg;
            end
            default: rdata_next = `AHC_RST_WORD32;
        endcase
    end

    // ------------------------------------------------------------
    // operand registers written by software
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            exec_reg <= 1'b0;
            desig_reg <= `AHC_RST_WORD16;
            src0_reg <= `AHC_RST_WORD16;
            src1_reg <= `AHC_RST_WORD16;
            src2_reg <= `AHC_RST_WORD16;
        end else if (bus_wr) begin
            case (addr_reg)
                `AHC_OFF_CTRL: exec_reg <= hwdata[`AHC_CTRL_EXEC];
                `AHC_OFF_DESIG: desig_reg <= hwdata[15:0];
                `AHC_OFF_SRC0: src0_reg <= hwdata[15:0];
                `AHC_OFF_SRC1: src1_reg <= hwdata[15:0];
                `AHC_OFF_SRC2: src2_reg <= hwdata[15:0];
                default: exec_reg <= exec_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // designator checks and launch
    // ------------------------------------------------------------
    // one limit per designator digit, parity digit on top
    assign field_max = {`AHC_PAR_MAX, `AHC_SBYTE_MAX, `AHC_CNT_MAX, `AHC_DIG_MAX};
    genvar f;
    generate
        for (f = 0; f < 4; f = f + 1) begin : g_field
            assign field_bad[f] = (desig_reg[f*4 +: 4] > field_max[f*4 +: 4]);
        end
    endgenerate
    assign range_bad = |field_bad; // see R13
    // a write of ctrl with the execution bit set launches one conversion
    assign start = bus_wr & (addr_reg == `AHC_OFF_CTRL) & hwdata[`AHC_CTRL_EXEC]
                 & state_reg[0]; // see R01
    // both sides pause whenever software drops the execution bit
    assign run = state_reg[1] & exec_reg; // see R01

    // ------------------------------------------------------------
    // source snapshot: writes to the source words during a run
    // cannot change the bytes of the conversion under way
    // ------------------------------------------------------------
    assign src_flat = {src2_reg, src1_reg, src0_reg};

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            src_lat_reg <= {3{`AHC_RST_WORD16}};
        end else if (start && !range_bad) begin
            src_lat_reg <= src_flat;
        end
    end

    // ------------------------------------------------------------
    // byte feeder into the two-entry buffer
    // ------------------------------------------------------------
    assign in_valid = run & (push_cnt_reg <= {1'b0, cnt_reg});
    // byte index climbs from lower to upper byte, then into the next word
    assign in_data = src_lat_reg[{byte_idx_reg, 3'b000} +: 8]; // see R11

    ahc_pair_buf #(
        .WIDTH(8)
    ) i_ahc_pair_buf (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    // ------------------------------------------------------------
    // byte checker and decoder
    // ------------------------------------------------------------
    assign out_ready = run;
    assign pop = out_valid & out_ready;
    assign dec = hex_decode(out_data[6:0]); // see R02 see R09
    // parity verdict for the byte at the buffer head
    always @* begin
        par_bad = 1'b0;
        case (par_reg)
            `AHC_PAR_NONE: par_bad = out_data[7]; // see R04
            `AHC_PAR_EVEN: par_bad = ^out_data; // see R05
            `AHC_PAR_ODD: par_bad = ~(^out_data); // see R06
            default: par_bad = 1'b1;
        endcase
    end
    assign byte_bad = par_bad | dec[4]; // see R13

    // ------------------------------------------------------------
    // destination digit lanes
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign lane_mask[g*4 +: 4] = {4{dig_reg == g}};
        end
    endgenerate

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            par_reg <= `AHC_PAR_NONE;
            cnt_reg <= 2'h0;
            dig_reg <= 2'h0;
            byte_idx_reg <= 3'h0;
            push_cnt_reg <= 3'h0;
            pop_cnt_reg <= 2'h0;
            work_reg <= `AHC_RST_WORD16;
            perr_reg <= 1'b0;
            dest_reg <= `AHC_RST_WORD16;
            err_reg <= 1'b0;
        end else begin
            if (bus_wr && addr_reg == `AHC_OFF_DEST) begin
                dest_reg <= hwdata[15:0];
            end
            case (state_reg)
                ST_IDLE: begin
                    if (start && range_bad) begin
                        err_reg <= 1'b1; // see R13 see R14
                    end else if (start) begin
                        // field layout gives 0121 and 1011 their meaning
                        par_reg <= desig_reg[13:12]; // see R03 see R07 see R08
                        byte_idx_reg <= {2'b00, desig_reg[8]};
                        cnt_reg <= desig_reg[5:4];
                        dig_reg <= desig_reg[1:0];
                        push_cnt_reg <= 3'h0;
                        pop_cnt_reg <= 2'h0;
                        // untouched digits carry over from the old word
                        work_reg <= dest_reg; // see R12
                        perr_reg <= 1'b0;
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (in_valid && in_ready) begin
                        byte_idx_reg <= byte_idx_reg + 3'h1; // see R11
                        push_cnt_reg <= push_cnt_reg + 3'h1;
                    end
                    if (pop) begin
                        work_reg <= (work_reg & ~lane_mask) | ({4{dec[3:0]}} & lane_mask);
                        dig_reg <= dig_reg + 2'h1; // see R11
                        pop_cnt_reg <= pop_cnt_reg + 2'h1;
                        perr_reg <= perr_reg | byte_bad;
                        if (pop_cnt_reg == cnt_reg) begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    if (!perr_reg) begin
                        dest_reg <= work_reg; // see R14
                    end
                    err_reg <= perr_reg; // see R13
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // status pins
    // ------------------------------------------------------------
    // busy is set with the launch and cleared as the sequencer leaves done
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'b0;
        end else if (start && !range_bad) begin
            busy_reg <= 1'b1;
        end else if (state_reg[2]) begin
            busy_reg <= 1'b0;
        end
    end

    assign error_flag_out = err_reg;
    assign busy_out = busy_reg;

endmodule

// >>> tb/ahc_hex_conv_props.sv
`timescale 1ns/1ns
module ahc_hex_conv_props (
    input wire mclk,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire error_flag_out,
    input wire busy_out
);
    // ----------------------------------------------------------------
    // bus and conversion checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic [4:0] busy_cnt;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn)
            busy_cnt <= 5'h0;
        else
            busy_cnt <= busy_out ? busy_cnt + 5'h1 : 5'h0;
    end
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_one_wait; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
    property p_short_wait; !hreadyout |=> hreadyout; endproperty
    a_short_wait: assert property (p_short_wait) else $error("wait state too long");
    property p_rdata_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_err_cause;
        $changed(error_flag_out) |->
            busy_out || $past(busy_out) || $past(busy_out, 2) || !$past(hreadyout);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error flag moved alone");
    property p_busy_start; $rose(busy_out) |-> !$past(hreadyout) || !$past(hreadyout, 2); endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without launch");
    property p_busy_len; busy_cnt < 5'h10; endproperty
    a_busy_len: assert property (p_busy_len) else $error("conversion too long");
    property p_reset_idle; !$past(rstn) |-> hreadyout && !busy_out && !error_flag_out; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    c_write: cover property (hsel && htrans[1] && hwrite);
    c_busy: cover property ($rose(busy_out));
    c_err: cover property ($rose(error_flag_out));
endmodule

bind ahc_hex_conv ahc_hex_conv_props i_ahc_hex_conv_props (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .error_flag_out(error_flag_out),
    .busy_out(busy_out)
);

// >>> tb/ahc_bus_master.sv
`timescale 1ns/1ns
`include "ahc_hex_conv_defs.vh"
module ahc_bus_master (
    input wire mclk,
    input wire hready,
    input wire [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic timed_out
);
    // ----------------------------------------------------------------
    // single word transfers, one at a time
    // ----------------------------------------------------------------
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = `AHC_HSIZE_WORD;
        hwdata = 32'h0000_0000;
        timed_out = 1'b0;
    end
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge mclk);
        while (hready !== 1'b1 && n < 64) begin
            @(posedge mclk);
            n++;
        end
        if (hready !== 1'b1)
            timed_out <= 1'b1;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hsize <= `AHC_HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wd : ~wd;
        wait_ready();
        rd = hrdata;
    endtask
endmodule

// >>> tb/ahc_hex_conv_test.sv
`timescale 1ns/1ns
`include "ahc_hex_conv_defs.vh"
module ahc_hex_conv_test;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    wire hsel, hwrite, hreadyout, hresp, error_flag_out, busy_out, timed_out;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    int err_total = 0;
    int check_count = 0;
    logic hang = 1'b0;
    logic [15:0] bad_dg [0:10] = '{16'h0000, 16'h1000, 16'h2000, 16'h0000, 16'h0000,
        16'h0000, 16'h3000, 16'h0200, 16'h0040, 16'h0004, 16'h0030};
    logic [15:0] bad_src [0:10] = '{16'h00B1, 16'h0031, 16'h0036, 16'h0047, 16'h003A,
        16'h0061, 16'h0031, 16'h0031, 16'h0031, 16'h0031, 16'h3132};
    always #50 mclk = ~mclk;
    ahc_hex_conv i_ahc_hex_conv (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .error_flag_out(error_flag_out), .busy_out(busy_out)
    );
    ahc_bus_master i_ahc_bus_master (
        .mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .timed_out(timed_out)
    );
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_ahc_bus_master.xfer(1'b1, a, d, x);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] g;
        i_ahc_bus_master.xfer(1'b0, a, 32'h0000_0000, g);
        check_count++;
        if (g !== e || hresp !== 1'b0) begin
            err_total++;
            $display("BAD %0t offset %h read %h resp %b expected %h", $time, a, g, hresp, e);
        end
    endtask
    task automatic conv(input logic [15:0] dg, input logic [15:0] s0, input logic [15:0] s1,
                        input logic [15:0] d0, input logic [15:0] de, input logic er);
        logic [31:0] st;
        int n;
        wr(`AHC_OFF_SRC0, {16'h0000, s0});
        wr(`AHC_OFF_SRC1, {16'h0000, s1});
        wr(`AHC_OFF_DEST, {16'h0000, d0});
        wr(`AHC_OFF_DESIG, {16'h0000, dg});
        wr(`AHC_OFF_CTRL, 32'h0000_0001);
        n = 0;
        st = 32'h0000_0002;
        while (st[1] !== 1'b0 && n < 40) begin
            i_ahc_bus_master.xfer(1'b0, `AHC_OFF_STATUS, 32'h0000_0000, st);
            n++;
        end
        if (n >= 40) begin
            $display("BAD %0t conversion never ended", $time);
            hang = 1'b1;
        end
        wr(`AHC_OFF_CTRL, 32'h0000_0000);
        chk(`AHC_OFF_DEST, {16'h0000, de});
        chk(`AHC_OFF_STATUS, {31'h0000_0000, er});
        check_count++;
        if (error_flag_out !== er || busy_out !== 1'b0) begin
            err_total++;
            $display("BAD %0t flag %b busy %b want %b", $time, error_flag_out, busy_out, er);
        end
    endtask
    function automatic logic [7:0] hexc(input int i);
        hexc = (i < 10) ? 8'h30 + 8'(i) : 8'h41 + 8'(i - 10);
    endfunction
    always @(posedge mclk) begin
        if (timed_out === 1'b1 || hang === 1'b1) begin
            err_total++;
            $display("BAD %0t wait limit reached", $time);
            report_and_stop();
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk(`AHC_OFF_STATUS, 32'h0000_0000);
        chk(`AHC_OFF_DEST, 32'h0000_0000);
        wr(`AHC_OFF_STATUS, 32'h0000_0003);
        chk(`AHC_OFF_STATUS, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        chk(8'h1C, 32'h0000_0000);
        wr(`AHC_OFF_SRC0, 32'h0000_3131);
        wr(`AHC_OFF_DESIG, 32'h0000_0121);
        chk(`AHC_OFF_DESIG, 32'h0000_0121);
        wr(`AHC_OFF_CTRL, 32'h0000_0000);
        chk(`AHC_OFF_STATUS, 32'h0000_0000);
        chk(`AHC_OFF_DEST, 32'h0000_0000);
        for (int i = 0; i < 11; i++) begin
            conv(16'h0000, 16'h0030, 16'h0000, 16'h5A5A, 16'h5A50, 1'b0);
            conv(bad_dg[i], bad_src[i], 16'h4733, 16'h5A5A, 16'h5A5A, 1'b1);
        end
        for (int i = 0; i < 16; i++) begin
            conv(16'h0000, {8'h00, hexc(i)}, 16'h0000, 16'hA5A5, {12'hA5A, 4'(i)}, 1'b0);
        end
        conv(16'h0121, 16'h3100, 16'h3332, 16'hABCD, 16'h321D, 1'b0);
        conv(16'h1011, 16'h36B1, 16'h0000, 16'h0000, 16'h0610, 1'b0);
        conv(16'h2033, 16'h46B6, 16'hB0C1, 16'h1111, 16'h60AF, 1'b0);
        report_and_stop();
    end
endmodule
